// ### hw/sfe_defs.vh
// Shared constants of the vector floating-point exception unit.
// Behaviour
// - Packed integer operations never raise numeric exceptions.
// - Exactly six exception classes are recognised.
// - Exceptions are precise, reported at instruction completion.
// - Each class has one flag, one mask bit.
// - Load/restore write masks; store/save read all.
// - Unmasked condition with OS support raises vector trap.
// - OS support clear gives invalid-opcode trap instead.
// - Invalid flag bit 0, invalid mask bit 7.
// - Masked invalid overwrites destination or sets processor flags.
// - Arithmetic with signalling NaN returns quieted NaN.
// - Square root of signalling NaN returns quieted NaN.
// - Square root of negative nonzero returns indefinite.
// - Max/min with any NaN returns second source.
// - Compare mask with NaN: zeros, ones for four predicates.
// - Precision conversion of signalling NaN returns quieted NaN.
// - Compare-to-flags with NaN sets not-comparable flags.
// - Invalid infinity/zero arithmetic returns quiet indefinite.
// - Bad float-to-integer conversion returns integer indefinite.
// - Non-numeric exceptions raised like any other instruction.
// - Unmasked invalid leaves operands unchanged, invokes handler.
// - Pre-computation conditions checked before post-computation ones.
// - Packed flags are OR of per-element flags.
`ifndef SFE_DEFS_VH
`define SFE_DEFS_VH
// Control/status field positions.
`define SFE_IE 0
`define SFE_DE 1
`define SFE_ZE 2
`define SFE_OE 3
`define SFE_UE 4
`define SFE_PE 5
`define SFE_FLAG_LSB 0
`define SFE_MASK_LSB 7
`define SFE_CS_RESET 32'h00001f80
`define SFE_CS_RW 32'h00001fbf
`define SFE_OS_BIT 10
// Register byte offsets.
`define SFE_ADDR_CS 4'h0
`define SFE_ADDR_SYS 4'h4
`define SFE_RESP_OKAY 2'h0
`define SFE_RESP_SLVERR 2'h2
// Operation codes.
`define SFE_OP_INT 4'h0
`define SFE_OP_ADD 4'h1
`define SFE_OP_SUB 4'h2
`define SFE_OP_MUL 4'h3
`define SFE_OP_DIV 4'h4
`define SFE_OP_SQRT 4'h5
`define SFE_OP_MAX 4'h6
`define SFE_OP_MIN 4'h7
`define SFE_OP_CMPMASK 4'h8
`define SFE_OP_CVTFP 4'h9
`define SFE_OP_CVTINT 4'ha
`define SFE_OP_COMI 4'hb
`define SFE_OP_UCOMI 4'hc
// Compare predicates.
`define SFE_PRED_LT 3'h1
`define SFE_PRED_LE 3'h2
`define SFE_PRED_UNORD 3'h3
`define SFE_PRED_NEQ 3'h4
`define SFE_PRED_NLT 3'h5
`define SFE_PRED_NLE 3'h6
// Processor flags {zero, parity, carry} for not comparable.
`define SFE_FLAGS_UNORD 3'h7
`endif

// ### hw/sfe_exception_unit.v
// Vector floating-point exception unit with control/status register and AXI4-Lite access.
`timescale 1ns/1ns
`include "sfe_defs.vh"
module sfe_exception_unit #(
	parameter [31:0] QNAN_SGL = 32'hffc00000,
	parameter [63:0] QNAN_DBL = 64'hfff8000000000000,
	parameter [31:0] INT_INDEF_SGL = 32'h80000000,
	parameter [63:0] INT_INDEF_DBL = 64'h0000000080000000
)(
	// Clock and reset
	input wire clk,
	input wire reset,

	// Completing instruction from the execution pipeline
	input wire opValid,
	input wire [3:0] opCode,
	input wire [2:0] opPred,
	input wire opPacked,
	input wire opDouble,
	input wire opFault,
	input wire [127:0] srcA,
	input wire [127:0] srcB,
	input wire [127:0] dpResult,
	input wire [2:0] dpFlags,
	input wire [3:0] dpOverflow,
	input wire [3:0] dpUnderflow,
	input wire [3:0] dpInexact,

	// Control/status load and store instructions
	input wire csLoadValid,
	input wire [31:0] csLoadData,
	output wire [31:0] csValue,

	// Results towards writeback and trap dispatch
	output reg doneQ,
	output reg destWriteQ,
	output reg [127:0] destDataQ,
	output reg flagsWriteQ,
	output reg [2:0] procFlagsQ,
	output reg vecTrapQ,
	output reg badOpcodeTrapQ,
	output reg nonNumericTrapQ,

	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	reg [31:0] cs_q;
	reg [31:0] cs_d;
	reg osSupport_q;
	reg osSupport_d;

	function [31:0] mergeStrb(input [31:0] old, input [31:0] wd, input [3:0] strb);
		integer b;
		begin
			mergeStrb = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					mergeStrb[8*b +: 8] = wd[8*b +: 8];
		end
	endfunction

	function [63:0] widenNan(input [31:0] s);
		widenNan = {s[31], 11'h7ff, s[22:0], 29'h0};
	endfunction

	function [31:0] narrowNan(input [63:0] d);
		narrowNan = {d[63], 8'hff, d[51:29]};
	endfunction

	// Per-element checks.
	wire [3:0] sInv;
	wire [3:0] sZero;
	wire [3:0] sDen;
	wire [3:0] sRep;
	wire [127:0] sRes;

	wire [1:0] dInv;
	wire [1:0] dZero;
	wire [1:0] dDen;
	wire [1:0] dRep;
	wire [127:0] dRes;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gSingle
			sfe_lane_check #(.W(32), .EW(8), .QNAN_INDEF(QNAN_SGL), .INT_INDEF(INT_INDEF_SGL)) uLane (
				.opCode(opCode),
				.pred(opPred),
				.srcA(srcA[32*g +: 32]),
				.srcB(srcB[32*g +: 32]),
				.dpRes(dpResult[32*g +: 32]),
				.laneInvalid(sInv[g]),
				.laneDivZero(sZero[g]),
				.laneDenorm(sDen[g]),
				.laneReplace(sRep[g]),
				.maskedRes(sRes[32*g +: 32])
			);
		end
		for (g = 0; g < 2; g = g + 1)
		begin : gDouble
			sfe_lane_check #(.W(64), .EW(11), .QNAN_INDEF(QNAN_DBL), .INT_INDEF(INT_INDEF_DBL)) uLane (
				.opCode(opCode),
				.pred(opPred),
				.srcA(srcA[64*g +: 64]),
				.srcB(srcB[64*g +: 64]),
				.dpRes(dpResult[64*g +: 64]),
				.laneInvalid(dInv[g]),
				.laneDivZero(dZero[g]),
				.laneDenorm(dDen[g]),
				.laneReplace(dRep[g]),
				.maskedRes(dRes[64*g +: 64])
			);
		end
	endgenerate

	// A widening conversion reads only the low two single elements, like the double forms.
	wire twoElem = opDouble || (opCode == `SFE_OP_CVTFP);
	// Active elements: scalar forms touch element 0 only.
	wire [3:0] elemEn = twoElem ? (opPacked ? 4'h3 : 4'h1) : (opPacked ? 4'hf : 4'h1);
	wire isFp = (opCode != `SFE_OP_INT);
	wire isFlagOp = (opCode == `SFE_OP_COMI) || (opCode == `SFE_OP_UCOMI);
	wire isNarrowing = (opCode == `SFE_OP_CVTFP) || (opCode == `SFE_OP_CVTINT);
	wire [3:0] eInv = (opDouble ? {2'h0, dInv} : sInv) & elemEn;
	wire [3:0] eZero = (opDouble ? {2'h0, dZero} : sZero) & elemEn;
	wire [3:0] eDen = (opDouble ? {2'h0, dDen} : sDen) & elemEn;
	wire [3:0] eRep = (opDouble ? {2'h0, dRep} : sRep) & elemEn;

	// Post-computation conditions are detected by the datapath, one bit per element.
	wire [3:0] eOvf = dpOverflow & elemEn;
	wire [3:0] eUnf = dpUnderflow & elemEn;
	wire [3:0] eInx = dpInexact & elemEn;

	wire [5:0] masks = cs_q[`SFE_MASK_LSB +: 6];

	reg [5:0] preFlags;
	reg [5:0] postFlags;
	reg [5:0] setFlags;
	reg preTrap;
	reg postTrap;
	reg [127:0] maskedData;
	integer i;

	// The six classes, each the OR over the active elements.
	always @*
	begin
		preFlags = 6'h0;
		postFlags = 6'h0;
		if (isFp)
		begin
			preFlags[`SFE_IE] = |eInv;
			preFlags[`SFE_ZE] = |eZero;
			preFlags[`SFE_DE] = |eDen;
			postFlags[`SFE_OE] = |eOvf;
			postFlags[`SFE_PE] = |eInx;
			// A masked underflow counts only when the tiny result was also inexact.
			postFlags[`SFE_UE] = masks[`SFE_UE] ? |(eUnf & eInx) : |eUnf;
		end

		preTrap = |(preFlags & ~masks);
		// Post-computation conditions are not examined once a pre-computation trap is taken.
		postTrap = ~preTrap & |(postFlags & ~masks);
		setFlags = preTrap ? preFlags : (preFlags | postFlags);
	end

	// Masked results substituted per element into the datapath result.
	always @*
	begin
		maskedData = dpResult;
		for (i = 0; i < 4; i = i + 1)
		begin
			if (eRep[i] && !twoElem)
				maskedData[32*i +: 32] = sRes[32*i +: 32];
		end
		// Double and widening forms carry two elements at most, so the upper slots are never indexed.
		for (i = 0; i < 2; i = i + 1)
		begin
			if (eRep[i] && twoElem)
			begin
				if (opDouble && isNarrowing)
					maskedData[32*i +: 32] = (opCode == `SFE_OP_CVTFP) ? narrowNan(dRes[64*i +: 64]) :
						dRes[64*i +: 32];
				else if (opDouble)
					maskedData[64*i +: 64] = dRes[64*i +: 64];
				else
					maskedData[64*i +: 64] = widenNan(sRes[32*i +: 32]);
			end
		end
	end

	// AXI4-Lite: address and data are taken together, one answer outstanding per direction.
	wire wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire rdTake = s_axi_arvalid & ~s_axi_rvalid;
	wire wrCs = wrTake && (s_axi_awaddr == `SFE_ADDR_CS);
	wire wrSys = wrTake && (s_axi_awaddr == `SFE_ADDR_SYS);
	assign s_axi_awready = wrTake;
	assign s_axi_wready = wrTake;
	assign s_axi_arready = rdTake;
	assign csValue = cs_q;

	// Only the trap-support bit of the system control word lives here; the other bits read as zero.
	wire [31:0] sysView = {{(31 - `SFE_OS_BIT){1'b0}}, osSupport_q, {`SFE_OS_BIT{1'b0}}};
	wire [31:0] sysMerged = mergeStrb(sysView, s_axi_wdata, s_axi_wstrb);

	always @*
	begin
		cs_d = cs_q;
		osSupport_d = osSupport_q;
		// The pipeline's load or restore wins over a bus write in the same cycle.
		if (csLoadValid)
			cs_d = csLoadData & `SFE_CS_RW;
		else if (wrCs)
			cs_d = mergeStrb(cs_q, s_axi_wdata, s_axi_wstrb) & `SFE_CS_RW;
		if (wrSys)
			osSupport_d = sysMerged[`SFE_OS_BIT];
		// Detection is ORed in last so a flag set in the same cycle as a clear survives.
		if (opValid && !opFault)
			cs_d[`SFE_FLAG_LSB +: 6] = cs_d[`SFE_FLAG_LSB +: 6] | setFlags;
	end

	// Architectural state.
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cs_q <= `SFE_CS_RESET;
			osSupport_q <= 1'b0;
		end
		else
		begin
			cs_q <= cs_d;
			osSupport_q <= osSupport_d;
		end
	end

	// Write response: it stands until the master accepts it, and no new write is taken meanwhile.
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SFE_RESP_OKAY;
		end
		else
		begin
			if (wrTake)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wrCs || wrSys) ? `SFE_RESP_OKAY : `SFE_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read data: the word is captured as the address is taken and stands until rready.
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `SFE_RESP_OKAY;
			s_axi_rdata <= 32'h0;
		end
		else
		begin
			if (rdTake)
			begin
				s_axi_rvalid <= 1'b1;
				case (s_axi_araddr)
					`SFE_ADDR_CS:
					begin
						s_axi_rdata <= cs_q;
						s_axi_rresp <= `SFE_RESP_OKAY;
					end
					`SFE_ADDR_SYS:
					begin
						s_axi_rdata <= sysView;
						s_axi_rresp <= `SFE_RESP_OKAY;
					end
					default:
					begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `SFE_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Completion stage: every report belongs to the instruction that just completed.
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			doneQ <= 1'b0;
			destWriteQ <= 1'b0;
			destDataQ <= 128'h0;
			flagsWriteQ <= 1'b0;
			procFlagsQ <= 3'h0;
			vecTrapQ <= 1'b0;
			badOpcodeTrapQ <= 1'b0;
			nonNumericTrapQ <= 1'b0;
		end
		else
		begin
			doneQ <= opValid;
			nonNumericTrapQ <= opValid & opFault;
			// A pre-computation trap keeps the destination untouched for the handler.
			destWriteQ <= opValid & ~opFault & ~preTrap & ~isFlagOp;
			flagsWriteQ <= opValid & ~opFault & ~preTrap & isFlagOp;
			vecTrapQ <= opValid & ~opFault & (preTrap | postTrap) & osSupport_q;
			badOpcodeTrapQ <= opValid & ~opFault & (preTrap | postTrap) & ~osSupport_q;

			// Result and processor flags are held for writeback until the next completion.
			if (opValid)
			begin
				destDataQ <= maskedData;
				procFlagsQ <= eRep[0] ? `SFE_FLAGS_UNORD : dpFlags;
			end
		end
	end
endmodule // sfe_exception_unit

// ### hw/sfe_lane_check.v
// One floating-point element: invalid, divide-by-zero and denormal detection plus masked result.
`timescale 1ns/1ns
`include "sfe_defs.vh"
module sfe_lane_check #(
	parameter W = 32,
	parameter EW = 8,
	parameter [W-1:0] QNAN_INDEF = 32'hffc00000,
	parameter [W-1:0] INT_INDEF = 32'h80000000
)(
	// Operation
	input wire [3:0] opCode,
	input wire [2:0] pred,
	// Operands and datapath result
	input wire [W-1:0] srcA,
	input wire [W-1:0] srcB,
	input wire [W-1:0] dpRes,
	// Findings
	output reg laneInvalid,
	output reg laneDivZero,
	output reg laneDenorm,
	output reg laneReplace,
	output reg [W-1:0] maskedRes
);
	localparam FW = W - 1 - EW;
	localparam integer EXP_LIMIT = (1 << (EW - 1)) + 30;
	localparam [W-1:0] LOW32 = {W{1'b1}} >> (W - 32);

	function isNan(input [W-1:0] x);
		isNan = (&x[W-2:FW]) & (|x[FW-1:0]);
	endfunction
	function isSnan(input [W-1:0] x);
		isSnan = isNan(x) & ~x[FW-1];
	endfunction
	function isInf(input [W-1:0] x);
		isInf = (&x[W-2:FW]) & ~(|x[FW-1:0]);
	endfunction
	function isZero(input [W-1:0] x);
		isZero = ~(|x[W-2:0]);
	endfunction
	function isDen(input [W-1:0] x);
		isDen = ~(|x[W-2:FW]) & (|x[FW-1:0]);
	endfunction
	function [W-1:0] quiet(input [W-1:0] x);
		quiet = x | ({{(W-1){1'b0}}, 1'b1} << (FW - 1));
	endfunction

	wire nanA = isNan(srcA);
	wire nanB = isNan(srcB);
	wire anyNan = nanA | nanB;
	wire anySnan = isSnan(srcA) | isSnan(srcB);
	wire infA = isInf(srcA);
	wire infB = isInf(srcB);
	wire zeroA = isZero(srcA);
	wire zeroB = isZero(srcB);
	wire [W-1:0] nanRes = nanA ? quiet(srcA) : quiet(srcB);
	wire usesB = (opCode != `SFE_OP_SQRT) && (opCode != `SFE_OP_CVTFP) && (opCode != `SFE_OP_CVTINT);
	reg badInf;

	always @*
	begin
		badInf = 1'b0;
		laneInvalid = 1'b0;
		laneDivZero = 1'b0;
		laneReplace = 1'b0;
		maskedRes = dpRes;
		laneDenorm = (opCode != `SFE_OP_INT) && (opCode != `SFE_OP_CVTINT) && (isDen(srcA) | (usesB & isDen(srcB)));
		case (opCode)
			`SFE_OP_ADD, `SFE_OP_SUB, `SFE_OP_MUL, `SFE_OP_DIV:
			begin
				case (opCode)
					`SFE_OP_ADD: badInf = infA & infB & (srcA[W-1] ^ srcB[W-1]);
					`SFE_OP_SUB: badInf = infA & infB & ~(srcA[W-1] ^ srcB[W-1]);
					`SFE_OP_MUL: badInf = (infA & zeroB) | (zeroA & infB);
					default: badInf = (zeroA & zeroB) | (infA & infB);
				endcase
				laneInvalid = anySnan | (badInf & ~anyNan);
				laneReplace = anyNan | badInf;
				maskedRes = anyNan ? nanRes : QNAN_INDEF;
				laneDivZero = (opCode == `SFE_OP_DIV) & zeroB & ~zeroA & ~nanA & ~infA;
			end
			`SFE_OP_SQRT:
			begin
				laneInvalid = isSnan(srcA) | (srcA[W-1] & ~zeroA & ~nanA);
				laneReplace = nanA | (srcA[W-1] & ~zeroA);
				maskedRes = nanA ? quiet(srcA) : QNAN_INDEF;
			end
			`SFE_OP_MAX, `SFE_OP_MIN:
			begin
				laneInvalid = anyNan;
				laneReplace = anyNan;
				maskedRes = srcB;
			end
			`SFE_OP_CMPMASK:
			begin
				laneInvalid = anySnan | (anyNan & ((pred == `SFE_PRED_LT) | (pred == `SFE_PRED_LE) |
					(pred == `SFE_PRED_NLT) | (pred == `SFE_PRED_NLE)));
				laneReplace = anyNan;
				maskedRes = {W{(pred >= `SFE_PRED_UNORD) && (pred <= `SFE_PRED_NLE)}};
			end
			`SFE_OP_CVTFP:
			begin
				laneInvalid = isSnan(srcA);
				laneReplace = nanA;
				maskedRes = quiet(srcA);
			end
			`SFE_OP_CVTINT:
			begin
				laneInvalid = nanA | infA | (srcA[W-2:FW] >= EXP_LIMIT);
				laneReplace = laneInvalid;
				maskedRes = (dpRes & ~LOW32) | INT_INDEF;
			end
			`SFE_OP_COMI, `SFE_OP_UCOMI:
			begin
				laneInvalid = (opCode == `SFE_OP_COMI) ? anyNan : anySnan;
				laneReplace = anyNan;
			end
			default:
			begin
				laneDenorm = 1'b0;
			end
		endcase
	end
endmodule // sfe_lane_check

// ### test/sfe_exception_unit_properties.sv
// Concurrent checks on the exception unit ports.
`timescale 1ns/1ns
`include "sfe_defs.vh"
module sfe_exception_unit_checker (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Pipeline and load side
	input wire opValid,
	input wire [3:0] opCode,
	input wire opFault,
	input wire csLoadValid,
	input wire [31:0] csValue,
	// Results
	input wire doneQ,
	input wire destWriteQ,
	input wire flagsWriteQ,
	input wire vecTrapQ,
	input wire badOpcodeTrapQ,
	input wire nonNumericTrapQ,
	// Bus
	input wire s_axi_awvalid,
	input wire s_axi_wvalid,
	input wire s_axi_bvalid,
	input wire s_axi_bready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Software writes may legally clear flags, so the sticky checks skip those cycles.
	wire csWrite = csLoadValid || (s_axi_awvalid && s_axi_wvalid);
	a_done_latency: assert property (opValid |=> doneQ)
		else $error("completion missing after op");
	a_done_cause: assert property (doneQ |-> $past(opValid))
		else $error("completion without op");
	a_fault_only: assert property (opValid && opFault |=> nonNumericTrapQ && !destWriteQ && !vecTrapQ)
		else $error("faulting op not reported alone");
	a_int_quiet: assert property (opValid && opCode == `SFE_OP_INT && !opFault && !csWrite
		|=> !vecTrapQ && !badOpcodeTrapQ && csValue[5:0] == $past(csValue[5:0])) else $error("integer op touched flags");
	a_flags_sticky: assert property (!csWrite |=> (csValue[5:0] & $past(csValue[5:0])) == $past(csValue[5:0]))
		else $error("flag cleared by hardware");
	a_trap_single: assert property (!(vecTrapQ && badOpcodeTrapQ))
		else $error("both trap kinds raised");
	a_trap_done: assert property (vecTrapQ || badOpcodeTrapQ || nonNumericTrapQ |-> doneQ)
		else $error("trap not at completion");
	a_cs_reserved: assert property ((csValue & ~`SFE_CS_RW) == 32'h00000000)
		else $error("reserved status bit set");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	c_vec_trap: cover property (vecTrapQ);
	c_bad_opcode: cover property (badOpcodeTrapQ);
	c_flags_write: cover property (flagsWriteQ);
endmodule // sfe_exception_unit_checker
bind sfe_exception_unit sfe_exception_unit_checker u_checker (.clk, .reset, .opValid, .opCode, .opFault, .csLoadValid,
	.csValue, .doneQ, .destWriteQ, .flagsWriteQ, .vecTrapQ, .badOpcodeTrapQ, .nonNumericTrapQ, .s_axi_awvalid,
	.s_axi_wvalid, .s_axi_bvalid, .s_axi_bready);

// ### test/sfe_pipe_model.sv
// Execution pipeline model that presents completing instructions.
`timescale 1ns/1ns
module sfe_pipe_model (
	// Clock
	input wire clk,
	// Completing instruction
	output reg opValid,
	output reg [3:0] opCode,
	output reg [2:0] opPred,
	output reg opPacked,
	output reg opDouble,
	output reg opFault,
	output reg [127:0] srcA,
	output reg [127:0] srcB,
	output reg [127:0] dpResult,
	output reg [2:0] dpFlags,
	output reg [3:0] dpOverflow,
	output reg [3:0] dpUnderflow,
	output reg [3:0] dpInexact
);
	initial
	begin
		{opValid, opCode, opPred, opPacked, opDouble, opFault, dpFlags} = 14'h0;
		{srcA, srcB, dpResult, dpOverflow, dpUnderflow, dpInexact} = 396'h0;
	end
	task issue(input [3:0] c, input [2:0] p, input pk, input db, input f, input [127:0] a, input [127:0] b,
		input [127:0] d, input [3:0] post);
		@(posedge clk);
		opValid <= 1'b1;
		{opCode, opPred, opPacked, opDouble, opFault} <= {c, p, pk, db, f};
		{srcA, srcB, dpResult, dpOverflow, dpUnderflow, dpInexact} <= {a, b, d, post, post, post};
		@(posedge clk);
		// Outside the valid cycle the operands are scrambled so stale values cannot pass.
		opValid <= 1'b0;
		{opCode, srcA, srcB, dpResult, dpOverflow} <= ~{c, a, b, d, post};
	endtask
endmodule // sfe_pipe_model

// ### test/tb_simd_fp_exception_unit.sv
// Self-checking bench of the exception unit.
`timescale 1ns/1ns
`include "sfe_defs.vh"
module tb_simd_fp_exception_unit;
	reg clk, reset, csLoadValid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [31:0] csLoadData, s_axi_wdata, rd;
	reg [3:0] s_axi_awaddr, s_axi_araddr;
	reg [1:0] resp;
	reg [5:0] expFlags;
	reg [127:0] ra, rb, rdp;
	integer num_errors, checks_done, seed, i;
	wire opValid, opPacked, opDouble, opFault, doneQ, destWriteQ, flagsWriteQ, vecTrapQ, badOpcodeTrapQ, nonNumericTrapQ;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [3:0] opCode, dpOverflow, dpUnderflow, dpInexact;
	wire [2:0] opPred, dpFlags, procFlagsQ;
	wire [127:0] srcA, srcB, dpResult, destDataQ;
	wire [31:0] csValue, s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	sfe_pipe_model pipe (.clk, .opValid, .opCode, .opPred, .opPacked, .opDouble, .opFault, .srcA, .srcB, .dpResult,
		.dpFlags, .dpOverflow, .dpUnderflow, .dpInexact);
	sfe_exception_unit dut (.clk, .reset, .opValid, .opCode, .opPred, .opPacked, .opDouble, .opFault, .srcA, .srcB,
		.dpResult, .dpFlags, .dpOverflow, .dpUnderflow, .dpInexact, .csLoadValid, .csLoadData, .csValue, .doneQ,
		.destWriteQ, .destDataQ, .flagsWriteQ, .procFlagsQ, .vecTrapQ, .badOpcodeTrapQ, .nonNumericTrapQ,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	always #10 clk = ~clk;
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task check(input [127:0] got, input [127:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task run(input [3:0] c, input [2:0] p, input pk, input db, input f, input [127:0] a, input [127:0] b,
		input [127:0] d, input [3:0] post);
		pipe.issue(c, p, pk, db, f, a, b, d, post);
		@(negedge clk);
	endtask
	task csLoad(input [31:0] d);
		@(posedge clk);
		csLoadValid <= 1'b1;
		csLoadData <= d;
		@(posedge clk);
		csLoadValid <= 1'b0;
		@(negedge clk);
	endtask
	task axiWr(input [3:0] a, input [31:0] d);
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		@(negedge clk);
		while (!(s_axi_awready && s_axi_wready)) @(negedge clk);
		@(posedge clk);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		@(negedge clk);
		while (!s_axi_bvalid) @(negedge clk);
		resp = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 1'b0;
	endtask
	task axiRd(input [3:0] a);
		@(posedge clk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		@(negedge clk);
		while (!s_axi_arready) @(negedge clk);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		@(negedge clk);
		while (!s_axi_rvalid) @(negedge clk);
		{rd, resp} = {s_axi_rdata, s_axi_rresp};
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask
	// Each masked case starts from clear flags, so the invalid flag must come from this op alone.
	task masked(input [3:0] c, input [2:0] p, input [31:0] a, input [31:0] b, input [31:0] e);
		csLoad(32'h00001f80);
		run(c, p, 1'b0, 1'b0, 1'b0, {96'h0, a}, {96'h0, b}, 128'h0, 4'h0);
		check(destDataQ[31:0], e);
		check(csValue, 32'h00001f81);
	endtask
	initial
	begin
		{clk, reset, csLoadValid, csLoadData, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = {2'h1, 36'h0};
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 42'h0;
		{num_errors, checks_done, seed, expFlags} = {32'h0, 32'h0, 32'h3aa068db, 6'h0};
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check(csValue, {19'h0, 6'h3f, 1'b0, expFlags});
		axiRd(`SFE_ADDR_SYS);
		check(rd, 32'h0);
		axiRd(4'h8);
		check(resp, `SFE_RESP_SLVERR);
		run(`SFE_OP_ADD, 3'h0, 1'b0, 1'b0, 1'b0, {96'h0, 32'h7f800001}, 128'h0, 128'h0, 4'h0);
		check({destWriteQ, destDataQ[31:0]}, {1'b1, 32'h7fc00001});
		expFlags[`SFE_IE] = 1'b1;
		check(csValue, {19'h0, 6'h3f, 1'b0, expFlags});
		run(`SFE_OP_INT, 3'h0, 1'b1, 1'b0, 1'b0, {4{32'h7f800001}}, 128'h0, 128'h0, 4'h0);
		check({vecTrapQ, badOpcodeTrapQ, csValue}, {2'h0, 19'h0, 6'h3f, 1'b0, expFlags});
		axiRd(`SFE_ADDR_CS);
		check(rd, 32'h00001f81);
		masked(`SFE_OP_SQRT, 3'h0, 32'h7f800001, 32'h0, 32'h7fc00001);
		masked(`SFE_OP_SQRT, 3'h0, 32'hbf800000, 32'h0, 32'hffc00000);
		masked(`SFE_OP_ADD, 3'h0, 32'h7f800000, 32'hff800000, 32'hffc00000);
		masked(`SFE_OP_SUB, 3'h0, 32'h7f800000, 32'h7f800000, 32'hffc00000);
		masked(`SFE_OP_MUL, 3'h0, 32'h7f800000, 32'h0, 32'hffc00000);
		masked(`SFE_OP_DIV, 3'h0, 32'h0, 32'h0, 32'hffc00000);
		masked(`SFE_OP_DIV, 3'h0, 32'h7f800000, 32'h7f800000, 32'hffc00000);
		masked(`SFE_OP_MAX, 3'h0, 32'h7fc00000, 32'h3f800000, 32'h3f800000);
		masked(`SFE_OP_MIN, 3'h0, 32'h3f800000, 32'h7f800001, 32'h7f800001);
		masked(`SFE_OP_CVTINT, 3'h0, 32'h7f800000, 32'h0, 32'h80000000);
		masked(`SFE_OP_CVTINT, 3'h0, 32'h4f800000, 32'h0, 32'h80000000);
		for (i = 0; i < 8; i = i + 1)
			masked(`SFE_OP_CMPMASK, i[2:0], 32'h7f800001, 32'h0, (i >= 3 && i <= 6) ? 32'hffffffff : 32'h0);
		for (i = 0; i < 2; i = i + 1)
		begin
			masked(i ? `SFE_OP_UCOMI : `SFE_OP_COMI, 3'h0, 32'h7f800001, 32'h0, 32'h0);
			check({flagsWriteQ, procFlagsQ}, {1'b1, `SFE_FLAGS_UNORD});
		end
		csLoad(32'h00001f80);
		run(`SFE_OP_CVTFP, 3'h0, 1'b0, 1'b0, 1'b0, {96'h0, 32'h7fa00000}, 128'h0, 128'h0, 4'h0);
		check(destDataQ[63:0], 64'h7ffc000000000000);
		csLoad(32'h00001f80);
		run(`SFE_OP_DIV, 3'h0, 1'b0, 1'b0, 1'b0, {96'h0, 32'h00000001}, 128'h0, 128'h0, 4'h0);
		check({destWriteQ, csValue}, {1'b1, 32'h00001f86});
		csLoad(32'h00001f80);
		run(`SFE_OP_ADD, 3'h0, 1'b0, 1'b1, 1'b0, {64'h0, 64'h7ff0000000000001}, 128'h0, 128'h0, 4'h0);
		check(destDataQ[63:0], 64'h7ff8000000000001);
		check(csValue, 32'h00001f81);
		// Random operands are kept normal and finite so only the planted element may raise a flag.
		for (i = 0; i < 4; i = i + 1)
		begin
			ra[32*i+:32] = ($random(seed) & 32'h1fffffff) | 32'h40000000;
			rb[32*i+:32] = ($random(seed) & 32'h1fffffff) | 32'h40000000;
			rdp[32*i+:32] = $random(seed);
		end
		csLoad(32'h00001f80);
		run(`SFE_OP_ADD, 3'h0, 1'b1, 1'b0, 1'b0, {32'h7f800001, ra[95:0]}, rb, rdp, 4'h0);
		check(destDataQ, {32'h7fc00001, rdp[95:0]});
		check(csValue, 32'h00001f81);
		csLoad(32'h00001f80);
		run(`SFE_OP_ADD, 3'h0, 1'b1, 1'b0, 1'b0, ra, rb, rdp, 4'h4);
		check(destDataQ, rdp);
		check(csValue, 32'h00001fb8);
		csLoad(32'h00001f80);
		run(`SFE_OP_ADD, 3'h0, 1'b0, 1'b0, 1'b1, {96'h0, 32'h7f800001}, 128'h0, 128'h0, 4'h0);
		check({nonNumericTrapQ, destWriteQ, vecTrapQ, csValue}, {3'h4, 32'h00001f80});
		axiWr(`SFE_ADDR_CS, 32'h00001f00);
		check(resp, `SFE_RESP_OKAY);
		run(`SFE_OP_ADD, 3'h0, 1'b0, 1'b0, 1'b0, {96'h0, 32'h7f800001}, 128'h0, 128'h0, 4'h0);
		check({vecTrapQ, badOpcodeTrapQ, destWriteQ}, 3'h2);
		axiWr(`SFE_ADDR_SYS, 32'h00000400);
		axiRd(`SFE_ADDR_SYS);
		check(rd, 32'h00000400);
		run(`SFE_OP_ADD, 3'h0, 1'b0, 1'b0, 1'b0, {96'h0, 32'h7f800001}, 128'h0, 128'h0, 4'h0);
		check({vecTrapQ, badOpcodeTrapQ, destWriteQ}, 3'h4);
		axiWr(4'hc, 32'hffffffff);
		check(resp, `SFE_RESP_SLVERR);
		stop_test;
	end
	initial
	begin
		#200000;
		num_errors = num_errors + 1;
		stop_test;
	end
endmodule // tb_simd_fp_exception_unit
